// ### logic/cpu_register_set.sv
/*
  Architectural register set of an 8-bit core with a small operation
  sequencer, reached over Avalon-MM. Assumes one clock, synchronous
  active-high reset; interrupt request is a pin and is synchronised.
*/
// Decided for this implementation: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cpu_register_set_regs.svh"

module cpu_register_set
  import cpu_register_set_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        irq_pin,
  output logic             oscillator_stopped,
  output logic             waiting,
  output logic             illegal_op
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0]  accumulator_reg;
    logic [7:0]  first_index_reg;
    logic [7:0]  second_index_reg;
    logic [7:0]  stack_pointer_reg;
    logic [7:0]  program_counter_high;
    logic [7:0]  program_counter_low;
    logic [7:0]  processor_status_reg;
    logic [7:0]  core_mode_reg;
    logic [7:0]  operand_reg;
    logic [7:0]  result_reg;
    logic [15:0] effective_addr_reg;
    logic [7:0]  stack_mem_top;
    logic        answered;
    logic        illegal;
    logic        branch_taken;
    logic        irq_meta;
    logic        irq_sync;
    core_state_e core_state;
    logic [31:0] readdata;
  } regs_s;

  regs_s r_reg;
  regs_s r_next;

  // Saved bytes stored by index; a small on-chip stack of 256 entries
  logic [7:0] stack_mem [0:255];
  logic [7:0] stack_wr_data;
  logic       stack_wr;
  logic [7:0] stack_wr_index;

  logic [15:0] stack_address;
  logic [7:0]  add_sum;
  logic        add_carry;
  logic        add_overflow;
  logic        subtract;
  logic [7:0]  add_b;
  logic        access;
  logic        wr_hit;
  logic [7:0]  wbyte;
  operation_e  op;

  assign subtract = (operation_e'(writedata[4:0]) == op_subtract);
  assign add_b    = subtract ? ~r_reg.operand_reg : r_reg.operand_reg;

  byte_adder u_adder
  (
    .operand_a (r_reg.accumulator_reg),
    .operand_b (add_b),
    .carry_in  (r_reg.processor_status_reg[`FLAG_CARRY]),
    .decimal   (r_reg.processor_status_reg[`FLAG_DECIMAL]),
    .sum       (add_sum),
    .carry_out (add_carry),
    .overflow  (add_overflow)
  );

  stack_address_gen u_stack
  (
    .stack_pointer (r_reg.stack_pointer_reg),
    .stack_page    (r_reg.core_mode_reg[`MODE_STACK_PAGE]),
    .stack_address (stack_address)
  );

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // One wait cycle per access: the answer is registered
  assign access      = (read || write) && clock_enable;
  assign waitrequest = (read || write) && !r_reg.answered;
  assign wr_hit      = write && access && !r_reg.answered;
  assign wbyte       = byteenable[0] ? writedata[7:0] : 8'h00;
  assign op          = operation_e'(writedata[4:0]);
  assign readdata    = r_reg.readdata;
  assign oscillator_stopped = (r_reg.core_state == st_stop);
  assign waiting     = (r_reg.core_state == st_wait);
  assign illegal_op  = r_reg.illegal;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    r_next         = r_reg;
    stack_wr       = 1'b0;
    stack_wr_data  = 8'h00;
    stack_wr_index = r_reg.stack_pointer_reg;
    r_next.irq_meta = irq_pin;
    r_next.irq_sync = r_reg.irq_meta;
    r_next.answered = access && !r_reg.answered;

    if (r_reg.irq_sync && !r_reg.processor_status_reg[`FLAG_IRQ_DISABLE]
        && r_reg.core_state == st_wait)
    begin
      r_next.core_state = st_run;
    end

    if (read && access && !r_reg.answered)
    begin
      r_next.readdata = 32'h0000_0000;
      case (address)
        `OFS_ACCUMULATOR:    r_next.readdata[7:0] = r_reg.accumulator_reg;
        `OFS_FIRST_INDEX:    r_next.readdata[7:0] = r_reg.first_index_reg;
        `OFS_SECOND_INDEX:   r_next.readdata[7:0] = r_reg.second_index_reg;
        `OFS_STACK_POINTER:  r_next.readdata[7:0] = r_reg.stack_pointer_reg;
        `OFS_PC_LOW:         r_next.readdata[7:0] = r_reg.program_counter_low;
        `OFS_PC_HIGH:        r_next.readdata[7:0] = r_reg.program_counter_high;
        `OFS_STATUS:         r_next.readdata[7:0] = r_reg.processor_status_reg & `STATUS_MASK;
        `OFS_CORE_MODE:      r_next.readdata[7:0] = r_reg.core_mode_reg;
        `OFS_OPERAND:        r_next.readdata[7:0] = r_reg.operand_reg;
        `OFS_RESULT:         r_next.readdata[7:0] = r_reg.result_reg;
        `OFS_STACK_ADDR:     r_next.readdata[15:0] = stack_address;
        `OFS_EFFECTIVE_ADDR: r_next.readdata[15:0] = r_reg.effective_addr_reg;
        `OFS_INFO:           r_next.readdata[12:0] = {r_reg.branch_taken, r_reg.illegal,
                                                      r_reg.core_state, r_reg.stack_mem_top};
        default:             r_next.readdata = 32'h0000_0000;
      endcase
    end

    if (wr_hit)
    begin
      case (address)
        `OFS_ACCUMULATOR:   r_next.accumulator_reg = wbyte;
        `OFS_FIRST_INDEX:   r_next.first_index_reg = wbyte;
        `OFS_SECOND_INDEX:  r_next.second_index_reg = wbyte;
        `OFS_STACK_POINTER: r_next.stack_pointer_reg = wbyte;
        `OFS_PC_LOW:        r_next.program_counter_low = wbyte;
        `OFS_PC_HIGH:       r_next.program_counter_high = wbyte;
        `OFS_STATUS:        r_next.processor_status_reg = wbyte & `STATUS_MASK;
        `OFS_CORE_MODE:     r_next.core_mode_reg = wbyte;
        `OFS_OPERAND:       r_next.operand_reg = wbyte;
        `OFS_OPERATION:
        begin
          r_next.illegal = 1'b0;
          r_next.branch_taken = 1'b0;
          case (op)
            op_none: ;
            op_load_accumulator:
            begin
              r_next.accumulator_reg = r_reg.operand_reg;
              r_next.result_reg = r_reg.operand_reg;
            end
            op_load_first_index:
            begin
              r_next.first_index_reg = r_reg.operand_reg;
              r_next.result_reg = r_reg.operand_reg;
            end
            op_load_second_index:
            begin
              r_next.second_index_reg = r_reg.operand_reg;
              r_next.result_reg = r_reg.operand_reg;
            end
            // flags follow result; in decimal mode Z and N follow the corrected sum, V the binary sum
            op_add, op_subtract:
            begin
              r_next.accumulator_reg = add_sum;
              r_next.result_reg = add_sum;
              r_next.processor_status_reg[`FLAG_CARRY] = add_carry;
              r_next.processor_status_reg[`FLAG_OVERFLOW] = add_overflow;
            end
            accum_push_op, status_push_op, software_break_op, op_interrupt:
            begin
              stack_wr = 1'b1;
              stack_wr_data = (op == accum_push_op) ? r_reg.accumulator_reg :
                              (op == software_break_op)
                                ? (r_reg.processor_status_reg | 8'h10)
                                : (r_reg.processor_status_reg & `STATUS_MASK);
              r_next.stack_pointer_reg = r_reg.stack_pointer_reg - 8'h01;
              if (op == software_break_op ||
                  (op == op_interrupt &&
                   !r_reg.processor_status_reg[`FLAG_IRQ_DISABLE]))
              begin
                r_next.processor_status_reg[`FLAG_IRQ_DISABLE] = 1'b1;
              end
              else if (op == op_interrupt)
              begin
                // Blocked request: nothing saved
                stack_wr = 1'b0;
                r_next.stack_pointer_reg = r_reg.stack_pointer_reg;
              end
            end
            accum_pop_op:
            begin
              r_next.stack_pointer_reg = r_reg.stack_pointer_reg + 8'h01;
              r_next.accumulator_reg = stack_mem[r_reg.stack_pointer_reg + 8'h01];
              r_next.result_reg = stack_mem[r_reg.stack_pointer_reg + 8'h01];
            end
            status_pop_op:
            begin
              r_next.stack_pointer_reg = r_reg.stack_pointer_reg + 8'h01;
              r_next.processor_status_reg =
                stack_mem[r_reg.stack_pointer_reg + 8'h01] & `STATUS_MASK;
            end
            product_op:
            begin
              {r_next.second_index_reg, r_next.accumulator_reg} =
                16'(r_reg.accumulator_reg * r_reg.operand_reg);
              r_next.result_reg = 8'(r_reg.accumulator_reg * r_reg.operand_reg);
            end
            op_divide:
            begin
              if (r_reg.operand_reg != 8'h00)
              begin
                r_next.accumulator_reg = r_reg.accumulator_reg / r_reg.operand_reg;
                r_next.second_index_reg = r_reg.accumulator_reg % r_reg.operand_reg;
                r_next.result_reg = r_reg.accumulator_reg / r_reg.operand_reg;
              end
            end
            oscillator_halt_op: r_next.core_state = st_stop;
            clock_wait_op:      r_next.core_state = st_wait;
            op_wake:            r_next.core_state = st_run;
            unsupported_op_one, unsupported_op_two: r_next.illegal = 1'b1;
            op_branch:
            begin
              case (r_reg.operand_reg[1:0])
                2'h0: r_next.branch_taken =
                        r_reg.processor_status_reg[`FLAG_CARRY] == r_reg.operand_reg[2];
                2'h1: r_next.branch_taken =
                        r_reg.processor_status_reg[`FLAG_ZERO] == r_reg.operand_reg[2];
                2'h2: r_next.branch_taken =
                        r_reg.processor_status_reg[`FLAG_OVERFLOW] == r_reg.operand_reg[2];
                default: r_next.branch_taken =
                        r_reg.processor_status_reg[`FLAG_NEGATIVE] == r_reg.operand_reg[2];
              endcase
              if (r_next.branch_taken)
                {r_next.program_counter_high, r_next.program_counter_low} =
                  {r_reg.program_counter_high, r_reg.program_counter_low} + 16'h0001;
            end
            op_index_address:
              r_next.effective_addr_reg = {8'h00, r_reg.operand_reg +
                (r_reg.operand_reg[7] ? r_reg.second_index_reg : r_reg.first_index_reg)};
            op_set_flag:
              r_next.processor_status_reg[writedata[10:8]] = 1'b1;
            op_clear_flag:
              r_next.processor_status_reg[writedata[10:8]] = 1'b0;
            default: r_next.illegal = 1'b1;
          endcase
          r_next.processor_status_reg[`FLAG_BREAK] = 1'b0;
          if (op == op_add || op == op_subtract || op == op_load_accumulator ||
              op == op_load_first_index || op == op_load_second_index ||
              op == accum_pop_op || op == product_op || op == op_divide)
          begin
            r_next.processor_status_reg[`FLAG_ZERO] = (r_next.result_reg == 8'h00);
            r_next.processor_status_reg[`FLAG_NEGATIVE] = r_next.result_reg[7];
          end
          // only status and accumulator saved by hardware
          if (stack_wr)
            r_next.stack_mem_top = stack_wr_data;
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      r_reg <= '{accumulator_reg: `RST_BYTE, first_index_reg: `RST_BYTE,
                 second_index_reg: `RST_BYTE, stack_pointer_reg: `RST_STACK_POINTER,
                 program_counter_high: `RST_BYTE, program_counter_low: `RST_BYTE,
                 processor_status_reg: `RST_STATUS, core_mode_reg: `RST_CORE_MODE,
                 operand_reg: `RST_BYTE, result_reg: `RST_BYTE,
                 effective_addr_reg: 16'h0000, stack_mem_top: `RST_BYTE,
                 answered: 1'b0, illegal: 1'b0, branch_taken: 1'b0,
                 irq_meta: 1'b0, irq_sync: 1'b0, core_state: st_run,
                 readdata: 32'h0000_0000};
    end
    else if (clock_enable)
    begin
      r_reg <= r_next;
    end
  end

  // Stack storage needs no reset: software never reads an unwritten slot
  always_ff @(posedge clock)
  begin
    if (clock_enable && stack_wr)
      stack_mem[stack_wr_index] <= stack_wr_data;
  end

endmodule : cpu_register_set

`default_nettype wire

// ### pkg/cpu_register_set_regs.svh
/*
  Constants of the core register set: bus offsets, field positions,
  reset values. Assumes nothing; definitions only.
*/
`ifndef CPU_REGISTER_SET_REGS_SVH
`define CPU_REGISTER_SET_REGS_SVH

// ****************************************************************
// Bus word offsets (byte addresses)
// ****************************************************************
`define OFS_ACCUMULATOR     6'h00
`define OFS_FIRST_INDEX     6'h04
`define OFS_SECOND_INDEX    6'h08
`define OFS_STACK_POINTER   6'h0C
`define OFS_PC_LOW          6'h10
`define OFS_PC_HIGH         6'h14
`define OFS_STATUS          6'h18
`define OFS_CORE_MODE       6'h1C
`define OFS_OPERATION       6'h20
`define OFS_OPERAND         6'h24
`define OFS_RESULT          6'h28
`define OFS_STACK_ADDR      6'h2C
`define OFS_EFFECTIVE_ADDR  6'h30
`define OFS_INFO            6'h34

// ****************************************************************
// Status flag positions
// ****************************************************************
`define FLAG_CARRY          0
`define FLAG_ZERO           1
`define FLAG_IRQ_DISABLE    2
`define FLAG_DECIMAL        3
`define FLAG_BREAK          4
`define FLAG_INDEX_MODE     5
`define FLAG_OVERFLOW       6
`define FLAG_NEGATIVE       7

// Stack page selection bit of the core mode register
`define MODE_STACK_PAGE     2

// Core mode register address in the special function area
`define CORE_MODE_SFR_ADDR  8'h3B

// ****************************************************************
// Reset values, stack page bytes and status mask
// ****************************************************************
`define RST_BYTE            8'h00
`define RST_STACK_POINTER   8'hFF
`define RST_STATUS          8'h04
`define RST_CORE_MODE       8'h00
`define STACK_PAGE_LOW      8'h00
`define STACK_PAGE_HIGH     8'h01
`define STATUS_MASK         8'hEF

`endif

// ### pkg/cpu_register_set_pkg.sv
/*
  Types of the core register set: operation codes and sequencer states.
  Assumes the constants header is compiled alongside.
*/
package cpu_register_set_pkg;

  typedef enum logic [4:0]
  {
    op_none              = 5'h00,
    op_load_accumulator  = 5'h01,
    op_load_first_index  = 5'h02,
    op_load_second_index = 5'h03,
    op_add               = 5'h04,
    op_subtract          = 5'h05,
    accum_push_op        = 5'h06,
    accum_pop_op         = 5'h07,
    status_push_op       = 5'h08,
    status_pop_op        = 5'h09,
    product_op           = 5'h0A,
    op_divide            = 5'h0B,
    oscillator_halt_op   = 5'h0C,
    clock_wait_op        = 5'h0D,
    unsupported_op_one   = 5'h0E,
    unsupported_op_two   = 5'h0F,
    op_branch            = 5'h10,
    op_index_address     = 5'h11,
    software_break_op    = 5'h12,
    op_interrupt         = 5'h13,
    op_wake              = 5'h14,
    op_set_flag          = 5'h15,
    op_clear_flag        = 5'h16
  } operation_e;

  typedef enum logic [2:0]
  {
    st_run  = 3'b001,
    st_wait = 3'b010,
    st_stop = 3'b100
  } core_state_e;

endpackage : cpu_register_set_pkg

// ### logic/byte_adder.sv
/*
  Byte adder with carry in, binary or decimal-corrected result.
  Assumes combinational use inside one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module byte_adder
(
  input  wire logic [7:0] operand_a,
  input  wire logic [7:0] operand_b,
  input  wire logic       carry_in,
  input  wire logic       decimal,
  output logic      [7:0] sum,
  output logic            carry_out,
  output logic            overflow
);

  logic [8:0] binary_sum;
  logic [4:0] low_nibble;
  logic [4:0] low_fixed;
  logic [4:0] high_nibble;
  logic [4:0] high_fixed;

  always_comb
  begin
    binary_sum  = {1'b0, operand_a} + {1'b0, operand_b} + {8'h00, carry_in};
    low_nibble  = {1'b0, operand_a[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, carry_in};
    low_fixed   = (low_nibble > 5'h09) ? low_nibble + 5'h06 : low_nibble;
    high_nibble = {1'b0, operand_a[7:4]} + {1'b0, operand_b[7:4]} + {4'h0, low_fixed[4]};
    high_fixed  = (high_nibble > 5'h09) ? high_nibble + 5'h06 : high_nibble;
    // Overflow only meaningful for binary signed data
    overflow    = (operand_a[7] == operand_b[7]) && (binary_sum[7] != operand_a[7]);
    if (decimal)
    begin
      sum       = {high_fixed[3:0], low_fixed[3:0]};
      carry_out = high_fixed[4];
    end
    else
    begin
      sum       = binary_sum[7:0];
      carry_out = binary_sum[8];
    end
  end

endmodule : byte_adder

`default_nettype wire

// ### logic/stack_address_gen.sv
/*
  Forms the 16-bit stack address from the page bit and stack pointer.
  Assumes both inputs come from flip-flops on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpu_register_set_regs.svh"

module stack_address_gen
(
  input  wire logic [7:0]  stack_pointer,
  input  wire logic        stack_page,
  output logic      [15:0] stack_address
);

  always_comb
  begin
    stack_address = {stack_page ? `STACK_PAGE_HIGH : `STACK_PAGE_LOW, stack_pointer};
  end

endmodule : stack_address_gen

`default_nettype wire

// ### verif/cpu_register_set_props.sv
/*
  Bus and state checks on the register set's ports.
  Assumes one clock, synchronous active-high reset; bound by the bind below.
*/
`timescale 1ns/1ps
`default_nettype none

module cpu_register_set_props
  import cpu_register_set_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        clock_enable,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        irq_pin,
  input wire logic        oscillator_stopped,
  input wire logic        waiting,
  input wire logic        illegal_op
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  logic rq;
  assign rq = read | write;

  a_wait_first: assert property ($rose(rq) |-> waitrequest)
    else $error("no wait cycle on new request");
  a_one_wait: assert property (rq && waitrequest && clock_enable |=> !rq || !waitrequest)
    else $error("answer late");
  a_idle_quiet: assert property (!rq |-> !waitrequest)
    else $error("wait without request");
  a_read_stands: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved");
  a_upper_zero: assert property (readdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_state_excl: assert property (!(oscillator_stopped && waiting))
    else $error("stop and wait together");
  a_stop_holds: assert property ((oscillator_stopped && !write && !irq_pin) [*4] |=> oscillator_stopped)
    else $error("stop left by itself");
  a_wait_holds: assert property ((waiting && !write && !irq_pin) [*4] |=> waiting)
    else $error("wait left by itself");
  a_reset_clear: assert property (disable iff (1'b0) reset && clock_enable |=> readdata == 32'h0 && !waiting && !oscillator_stopped && !illegal_op)
    else $error("reset state wrong");
  cover property (read && !waitrequest);
  cover property (write && !waitrequest);
  cover property ($rose(waiting));
  cover property ($rose(illegal_op));
endmodule : cpu_register_set_props

bind cpu_register_set cpu_register_set_props u_props (.clock(clock), .reset(reset),
  .clock_enable(clock_enable), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest), .irq_pin(irq_pin), .oscillator_stopped(oscillator_stopped),
  .waiting(waiting), .illegal_op(illegal_op));

`default_nettype wire

// ### verif/cpu_register_set_tb.sv
/*
  Self-checking bench for the register set over Avalon-MM.
  Assumes the constants header and the package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpu_register_set_regs.svh"

module cpu_register_set_tb
  import cpu_register_set_pkg::*;
;
  logic        clock = 0, reset = 1, read = 0, write = 0, irq_pin = 0;
  logic [5:0]  address = 6'h00;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic        waitrequest, oscillator_stopped, waiting, illegal_op, tk;
  logic [7:0]  a, b, s, v[6];
  logic [8:0]  e;
  logic [15:0] p;
  int          errors = 0, num_checks = 0, pos;
  operation_e  ops[3] = '{unsupported_op_one, unsupported_op_two, op_set_flag};

  cpu_register_set DUT (.clock(clock), .reset(reset), .clock_enable(1'b1), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
    .readdata(readdata), .waitrequest(waitrequest), .irq_pin(irq_pin),
    .oscillator_stopped(oscillator_stopped), .waiting(waiting), .illegal_op(illegal_op));

  initial begin
    forever #4 clock = ~clock;
  end

  task end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until the rising edge after waitrequest is seen low at a falling edge
  task bus(input logic w, input logic [5:0] ad, input logic [31:0] d);
    int n;
    @(posedge clock);
    write <= w; read <= !w; address <= ad; writedata <= d;
    n = 0;
    do begin @(negedge clock); n++; end while (waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin errors++; end_sim(); end
    @(posedge clock);
    q = readdata;
    write <= 0; read <= 0;
  endtask : bus

  task wr(input logic [5:0] ad, input logic [7:0] d);
    bus(1, ad, {24'hA5A5A5, d});
  endtask : wr

  task rd(input logic [5:0] ad, input logic [31:0] exp);
    bus(0, ad, 32'h0);
    chk(q, exp);
  endtask : rd

  task op(input operation_e c, input logic [2:0] f);
    bus(1, `OFS_OPERATION, {21'h0, f, 3'h0, c});
  endtask : op

  task rst;
    reset <= 1;
    repeat (20) @(posedge clock);
    reset <= 0;
  endtask : rst

  function automatic logic [8:0] add_exp(input logic [7:0] x, y, input logic c, dec);
    logic [4:0] lo, hi;
    if (!dec) return x + y + c;
    lo = x[3:0] + y[3:0] + c;
    if (lo > 9) lo = lo + 6;
    hi = x[7:4] + y[7:4] + lo[4];
    if (hi > 9) hi = hi + 6;
    return {hi[4], hi[3:0], lo[3:0]};
  endfunction : add_exp

  initial begin
    void'($urandom(5));
    rst();
    rd(`OFS_STACK_POINTER, {24'h0, `RST_STACK_POINTER});
    rd(`OFS_STATUS, {24'h0, `RST_STATUS});
    rd(`OFS_STACK_ADDR, {16'h0, `STACK_PAGE_LOW, `RST_STACK_POINTER});
    rd(6'h3C, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 6; i++)
    begin
      for (int r = 0; r < 6; r++) begin v[r] = 8'($urandom); wr(6'(4 * r), v[r]); end
      for (int r = 0; r < 6; r++) rd(6'(4 * r), {24'h0, v[r]});
    end
    wr(`OFS_STATUS, 8'hFF);
    rd(`OFS_STATUS, {24'h0, `STATUS_MASK});
    s = 8'($urandom);
    wr(`OFS_STACK_POINTER, s);
    wr(`OFS_CORE_MODE, 8'(1 << `MODE_STACK_PAGE));
    rd(`OFS_STACK_ADDR, {16'h0, `STACK_PAGE_HIGH, s});
    a = 8'($urandom);
    b = 8'($urandom);
    wr(`OFS_ACCUMULATOR, a);
    op(accum_push_op, 0);
    rd(`OFS_STACK_POINTER, {24'h0, 8'(s - 1)});
    wr(`OFS_ACCUMULATOR, ~a);
    op(accum_pop_op, 0);
    rd(`OFS_ACCUMULATOR, {24'h0, a});
    wr(`OFS_STATUS, b);
    op(status_push_op, 0);
    wr(`OFS_STATUS, ~b);
    op(status_pop_op, 0);
    rd(`OFS_STATUS, {24'h0, b & `STATUS_MASK});
    $display("stack test done");
    for (int i = 0; i < 12; i++)
    begin
      a = i[0] ? {4'(($urandom) % 10), 4'(($urandom) % 10)} : 8'($urandom);
      b = i[0] ? {4'(($urandom) % 10), 4'(($urandom) % 10)} : 8'($urandom);
      if (i == 0) begin a = 8'hFF; b = 8'h01; end
      wr(`OFS_STATUS, i[0] ? 8'h08 : 8'h00);
      if (i[1]) op(op_set_flag, 3'(`FLAG_CARRY));
      wr(`OFS_ACCUMULATOR, a);
      wr(`OFS_OPERAND, b);
      op(op_add, 0);
      e = add_exp(a, b, i[1], i[0]);
      rd(`OFS_ACCUMULATOR, {24'h0, e[7:0]});
      bus(0, `OFS_STATUS, 32'h0);
      chk({31'h0, q[`FLAG_CARRY]}, {31'h0, e[8]});
      if (!i[0]) chk({31'h0, q[`FLAG_ZERO]}, {31'h0, e[7:0] == 8'h00});
      else chk({31'h0, q[`FLAG_CARRY]}, {31'h0, e[8]});
    end
    a = 8'($urandom);
    b = 8'($urandom);
    p = a * b;
    wr(`OFS_ACCUMULATOR, a);
    wr(`OFS_OPERAND, b);
    op(product_op, 0);
    rd(`OFS_SECOND_INDEX, {24'h0, p[15:8]});
    wr(`OFS_OPERAND, 8'h00);
    op(op_divide, 0);
    rd(`OFS_ACCUMULATOR, {24'h0, p[7:0]});
    a = 8'($urandom) & 8'h7F;
    b = 8'($urandom) & 8'h3F;
    wr(`OFS_FIRST_INDEX, a);
    wr(`OFS_SECOND_INDEX, b);
    wr(`OFS_OPERAND, 8'h10);
    op(op_index_address, 0);
    rd(`OFS_EFFECTIVE_ADDR, {24'h0, 8'(a + 8'h10)});
    wr(`OFS_OPERAND, 8'h90);
    op(op_index_address, 0);
    rd(`OFS_EFFECTIVE_ADDR, {24'h0, 8'(b + 8'h90)});
    wr(`OFS_STATUS, 8'h01);
    wr(`OFS_ACCUMULATOR, a);
    wr(`OFS_OPERAND, b);
    op(op_subtract, 0);
    rd(`OFS_ACCUMULATOR, {24'h0, 8'(a - b)});
    bus(0, `OFS_STATUS, 32'h0);
    chk({31'h0, q[`FLAG_CARRY]}, {31'h0, a >= b});
    for (int f = 0; f < 8; f++)
    begin
      s = 8'($urandom) & 8'hC3;
      pos = (f % 4 < 2) ? f % 4 : f % 4 + 4;
      tk = s[pos] == f[2];
      wr(`OFS_PC_LOW, 8'h20);
      wr(`OFS_STATUS, s);
      wr(`OFS_OPERAND, {5'h0, f[2], 2'(f)});
      op(op_branch, 0);
      rd(`OFS_PC_LOW, {24'h0, tk ? 8'h21 : 8'h20});
    end
    for (int i = 0; i < 3; i++)
    begin
      op(ops[i], 0);
      chk({31'h0, illegal_op}, {31'h0, i < 2});
    end
    wr(`OFS_STATUS, 8'h00);
    op(software_break_op, 0);
    rd(`OFS_STATUS, {24'h0, 8'(1 << `FLAG_IRQ_DISABLE)});
    rd(`OFS_INFO, 32'h0000_0110);
    bus(0, `OFS_STACK_POINTER, 32'h0);
    p = {8'h00, q[7:0]};
    op(op_interrupt, 0);
    rd(`OFS_STACK_POINTER, {24'h0, p[7:0]});
    wr(`OFS_OPERAND, 8'h00);
    op(op_load_first_index, 0);
    bus(0, `OFS_STATUS, 32'h0);
    chk({31'h0, q[`FLAG_ZERO]}, 32'h1);
    $display("operation test done");
    rst();
    op(clock_wait_op, 0);
    irq_pin <= 1;
    repeat (8) @(posedge clock);
    chk({31'h0, waiting}, 32'h1);
    irq_pin <= 0;
    rst();
    op(op_clear_flag, 3'(`FLAG_IRQ_DISABLE));
    op(clock_wait_op, 0);
    chk({31'h0, waiting}, 32'h1);
    irq_pin <= 1;
    for (int n = 0; n < 20 && waiting !== 1'b0; n++) @(posedge clock);
    chk({31'h0, waiting}, 32'h0);
    irq_pin <= 0;
    rst();
    op(oscillator_halt_op, 0);
    repeat (6) @(posedge clock);
    chk({31'h0, oscillator_stopped}, 32'h1);
    op(op_wake, 0);
    chk({31'h0, oscillator_stopped}, 32'h0);
    rst();
    $display("power test done");
    end_sim();
  end

  // Hang guard: a stuck run ends as a failure
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    end_sim();
  end
endmodule : cpu_register_set_tb

`default_nettype wire
